// ---- inc/cps_pkg.sv ----
// constants, carrier types and helpers for the clock, power and serial port control block
// ----------------------------------------------------------------------------
// Function
// R01: a read-only lock flag in bit 7 of the clock control register reads 1 while the loop is locked.
// R02: with the unlock automute bit set (reset 1) the converter output is muted while the loop is unlocked.
// R03: the source select bit sends the master clock (0) or the frame clock (1) to the loop, frame clock only 32-192 kHz.
// R04: the three-bit multiplier code gives 128, 256, 384, 512 or 768 times fs, codes 101-111 reserved, reset 001.
// R05: software sets the multiplier code to match the real master clock and rate, ratios valid for 32-48 kHz.
// R06: frame clock polarity 0 means low half first, 1 means high half first.
// R07: bit edge select 0 (reset) changes serial data on the falling bit clock edge, 1 on the rising edge.
// R08: regulator enable (bit 5) and reference enable (bit 4) power their blocks down at 0, up at 1, both reset on.
// R09: bits 3..0 enable channels 4..1 one by one, 0 powers a channel down, all reset on.
// R10: format 00 is delayed one bit clock, 01 left justified, 10 right justified 24-bit, 11 right justified 16-bit.
// R11: mode 000 is stereo, 001 two-slot, 010 four-slot, 011 eight-slot, 100 sixteen-slot multiplexing.
// R12: rate code 000 8-12, 001 16-24, 010 32-48 (reset), 011 64-96, 100 128-192 kHz.
// R13: soft reset returns all internal circuitry and these control registers to their defaults.
// ----------------------------------------------------------------------------
package cps_pkg;

    // ------------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFF_CLK_CTL   = 8'h01;
    localparam logic [7:0] OFF_PWR_PORT  = 8'h04;
    localparam logic [7:0] OFF_FMT_CTL   = 8'h05;
    localparam logic [7:0] RST_CLK_CTL   = 8'h41;
    localparam logic [7:0] RST_PWR_PORT  = 8'h3f;
    localparam logic [7:0] RST_FMT_CTL   = 8'h02;
    localparam logic [7:0] CLK_CTL_WMASK = 8'h7f;

    localparam int BIT_LOCK     = 7;
    localparam int BIT_AUTOMUTE = 6;
    localparam int BIT_CLK_SRC  = 4;
    localparam int MCS_LSB      = 0;
    localparam int BIT_POL      = 7;
    localparam int BIT_EDGE     = 6;
    localparam int BIT_REG_EN   = 5;
    localparam int BIT_VREF_EN  = 4;
    localparam int CHAN_LSB     = 0;
    localparam int FMT_LSB      = 6;
    localparam int MODE_LSB     = 3;
    localparam int RATE_LSB     = 0;

    // ------------------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------------------
    localparam logic [2:0] MCS_128 = 3'h0;
    localparam logic [2:0] MCS_256 = 3'h1;
    localparam logic [2:0] MCS_384 = 3'h2;
    localparam logic [2:0] MCS_512 = 3'h3;
    localparam logic [2:0] MCS_768 = 3'h4;
    localparam logic [9:0] RATIO_128 = 10'h080;
    localparam logic [9:0] RATIO_256 = 10'h100;
    localparam logic [9:0] RATIO_384 = 10'h180;
    localparam logic [9:0] RATIO_512 = 10'h200;
    localparam logic [9:0] RATIO_768 = 10'h300;

    typedef enum logic [1:0] {
        CPS_FMT_DELAY1 = 2'b00,
        CPS_FMT_LJ     = 2'b01,
        CPS_FMT_RJ24   = 2'b10,
        CPS_FMT_RJ16   = 2'b11
    } cps_fmt_t;

    localparam logic [2:0] MODE_STEREO = 3'h0;
    localparam logic [2:0] MODE_TDM2   = 3'h1;
    localparam logic [2:0] MODE_TDM4   = 3'h2;
    localparam logic [2:0] MODE_TDM8   = 3'h3;
    localparam logic [2:0] MODE_TDM16  = 3'h4;
    localparam logic [2:0] RATE_32K    = 3'h2;

    // ------------------------------------------------------------------------
    // link framing
    // ------------------------------------------------------------------------
    localparam logic [9:0] FRAME_BITS_2  = 10'h040;
    localparam logic [9:0] FRAME_BITS_4  = 10'h080;
    localparam logic [9:0] FRAME_BITS_8  = 10'h100;
    localparam logic [9:0] FRAME_BITS_16 = 10'h200;
    localparam logic [4:0] DLY_DELAY1    = 5'h01;
    localparam logic [4:0] DLY_LJ        = 5'h00;
    localparam logic [4:0] DLY_RJ24      = 5'h08;
    localparam logic [4:0] DLY_RJ16      = 5'h10;
    localparam logic [4:0] WID_24        = 5'h18;
    localparam logic [4:0] WID_16        = 5'h10;
    localparam logic [4:0] MSB_IDX       = 5'h17;
    // two sync stages plus the register step between frame edge and first driven bit
    localparam logic [8:0] LINK_LAT      = 9'h003;
    // soft reset held this many control clocks so the slower bit clock cannot miss it
    localparam logic [4:0] SRST_STRETCH  = 5'h1a;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0][23:0] ch;
    } cps_frame_t;

    typedef struct packed {
        logic       regulator_enable;
        logic       vref_enable;
        logic [3:0] channel_enable;
    } cps_power_t;

    typedef struct packed {
        logic       frame_source;
        logic [2:0] clock_multiplier_select;
        logic [9:0] ratio;
        logic       mute;
    } cps_clock_t;

    typedef struct packed {
        cps_fmt_t   serial_format_select;
        logic [2:0] port_mode_select;
        logic       frame_clock_polarity;
        logic       bit_edge_select;
        logic       soft_reset;
    } cps_link_cfg_t;

    function automatic logic [9:0] cps_ratio(input logic [2:0] code);
        case (code)
            MCS_128: cps_ratio = RATIO_128;
            MCS_256: cps_ratio = RATIO_256;
            MCS_384: cps_ratio = RATIO_384;
            MCS_512: cps_ratio = RATIO_512;
            MCS_768: cps_ratio = RATIO_768;
            default: cps_ratio = 10'h000;
        endcase
    endfunction

endpackage

// ---- rtl/cps_fifo.sv ----
// small valid/ready buffer with flush, depth and width set by parameters
`timescale 1ns/10ps
`default_nettype none
module cps_fifo
    import cps_pkg::*;
#(
    parameter int WIDTH = 96,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } cps_fifo_state_t;

    cps_fifo_state_t st_reg;
    cps_fifo_state_t st_next;
    logic            push;
    logic            pop;

    assign in_ready  = (st_reg.cnt < (PW+1)'(DEPTH));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data  = st_reg.mem[st_reg.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = (st_reg.wp == PW'(DEPTH-1)) ? '0 : st_reg.wp + PW'(1);
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == PW'(DEPTH-1)) ? '0 : st_reg.rp + PW'(1);
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + (PW+1)'(1);
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - (PW+1)'(1);
        end
        if (flush) begin
            st_next.wp  = '0;
            st_next.rp  = '0;
            st_next.cnt = '0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_fifo_bound: assert property (@(posedge mclk) disable iff (!arst_n)
        st_reg.cnt <= (PW+1)'(DEPTH))
        else $error("buffer count above depth");
    a_fifo_fill: assert property (@(posedge mclk) disable iff (!arst_n)
        (push && !pop && !flush) |=> (st_reg.cnt == $past(st_reg.cnt) + (PW+1)'(1)))
        else $error("buffer push did not raise count");
    c_fifo_full: cover property (@(posedge mclk) disable iff (!arst_n) !in_ready && in_valid);
endmodule
`default_nettype wire

// ---- rtl/cps_config_top.sv ----
// clock, power and serial port control registers with the serial audio transmitter
`timescale 1ns/10ps
`default_nettype none
module cps_config_top
    import cps_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        soft_rst,
    input  wire logic        loop_locked,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    input  wire logic        samp_valid,
    output logic             samp_ready,
    input  wire cps_frame_t  samp_data,
    output cps_power_t       pwr_out,
    output cps_clock_t       clk_out,
    output logic [2:0]       sample_rate_range,
    output logic             src_rate_bad,
    input  wire logic        bclk,
    input  wire logic        lrclk_in,
    output logic             sdata_out
);
    // ------------------------------------------------------------------------
    // control side state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] clk_ctl;
        logic [7:0] pwr_port;
        logic [7:0] fmt_ctl;
        logic [7:0] rdata;
        logic [1:0] lock_sync;
        cps_frame_t hold;
        logic       req;
        logic [1:0] ack_sync;
        cps_power_t pwr;
        cps_clock_t clk;
        logic [2:0] rate;
        logic       rate_bad;
        logic [4:0] srst_cnt;
    } cps_ctl_state_t;

    typedef struct packed {
        cps_link_cfg_t cfg_s0;
        cps_link_cfg_t cfg_s1;
        logic [1:0]    req_sync;
        logic          ack;
        logic [1:0]    lr_sync;
        logic          lr_prev;
        logic [8:0]    pos;
        cps_frame_t    word;
        logic          sout;
    } cps_link_state_t;

    cps_ctl_state_t  c_reg;
    cps_ctl_state_t  c_next;
    cps_link_state_t l_reg;
    cps_link_state_t l_next;
    logic            sout_neg_reg;
    cps_frame_t      fifo_data;
    logic            fifo_valid;
    logic            take;
    cps_link_cfg_t   link_cfg;
    logic            muted;

    cps_fifo #(
        .WIDTH ($bits(cps_frame_t)),
        .DEPTH (2)
    ) u_buf (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .flush     (soft_rst),
        .in_valid  (samp_valid),
        .in_ready  (samp_ready),
        .in_data   (samp_data),
        .out_valid (fifo_valid),
        .out_ready (take),
        .out_data  (fifo_data)
    );

    // a word moves on only when the previous handshake has come back
    assign take  = fifo_valid && (c_reg.req == c_reg.ack_sync[1]) && !soft_rst;
    assign muted = c_reg.clk_ctl[BIT_AUTOMUTE] && !c_reg.lock_sync[1];

    // config bits move as a bundle of levels; a field may land one bit clock
    // apart from its neighbour while software is rewriting it
    always_comb begin
        link_cfg                      = '0;
        link_cfg.serial_format_select = cps_fmt_t'(c_reg.fmt_ctl[FMT_LSB +: 2]);
        link_cfg.port_mode_select     = c_reg.fmt_ctl[MODE_LSB +: 3];
        link_cfg.frame_clock_polarity = c_reg.pwr_port[BIT_POL];
        link_cfg.bit_edge_select      = c_reg.pwr_port[BIT_EDGE];
        link_cfg.soft_reset           = (c_reg.srst_cnt != 5'h00);
    end

    // ------------------------------------------------------------------------
    // register file and control outputs
    // ------------------------------------------------------------------------
    always_comb begin
        c_next           = c_reg;
        c_next.lock_sync = {c_reg.lock_sync[0], loop_locked};
        c_next.ack_sync  = {c_reg.ack_sync[0], l_reg.ack};
        c_next.srst_cnt  = (c_reg.srst_cnt != 5'h00) ? c_reg.srst_cnt - 5'h01 : 5'h00;
        if (reg_wr) begin
            case (reg_addr)
                OFF_CLK_CTL:  c_next.clk_ctl  = reg_wdata & CLK_CTL_WMASK;
                OFF_PWR_PORT: c_next.pwr_port = reg_wdata;
                OFF_FMT_CTL:  c_next.fmt_ctl  = reg_wdata;
                default:      c_next.clk_ctl  = c_reg.clk_ctl;
            endcase
        end
        case (reg_addr)
            OFF_CLK_CTL:  c_next.rdata = {c_reg.lock_sync[1], c_reg.clk_ctl[6:0]}; // R01
            OFF_PWR_PORT: c_next.rdata = c_reg.pwr_port;
            OFF_FMT_CTL:  c_next.rdata = c_reg.fmt_ctl;
            default:      c_next.rdata = 8'h00;
        endcase
        if (take) begin
            c_next.hold = fifo_data;
            for (int i = 0; i < 4; i++) begin
                if (muted || !c_reg.pwr_port[CHAN_LSB + i]) begin // R02 R09
                    c_next.hold.ch[i] = '0;
                end
            end
            c_next.req = ~c_reg.req;
        end
        // soft reset beats a write in the same cycle
        if (soft_rst) begin // R13
            c_next.clk_ctl  = RST_CLK_CTL & CLK_CTL_WMASK;
            c_next.pwr_port = RST_PWR_PORT;
            c_next.fmt_ctl  = RST_FMT_CTL;
            c_next.hold     = '0;
            c_next.srst_cnt = SRST_STRETCH;
        end
        c_next.pwr.regulator_enable        = c_next.pwr_port[BIT_REG_EN]; // R08
        c_next.pwr.vref_enable             = c_next.pwr_port[BIT_VREF_EN]; // R08
        c_next.pwr.channel_enable          = c_next.pwr_port[CHAN_LSB +: 4]; // R09
        c_next.clk.frame_source            = c_next.clk_ctl[BIT_CLK_SRC]; // R03
        c_next.clk.clock_multiplier_select = c_next.clk_ctl[MCS_LSB +: 3];
        c_next.clk.ratio                   = cps_ratio(c_next.clk_ctl[MCS_LSB +: 3]); // R04
        c_next.clk.mute                    = c_next.clk_ctl[BIT_AUTOMUTE] && !c_reg.lock_sync[1]; // R02
        c_next.rate                        = c_next.fmt_ctl[RATE_LSB +: 3]; // R12
        // frame clock as loop source is only good from 32 kHz upward (R05 is software's part)
        c_next.rate_bad = c_next.clk_ctl[BIT_CLK_SRC] && (c_next.fmt_ctl[RATE_LSB +: 3] < RATE_32K); // R03
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            c_reg                             <= '0;
            c_reg.clk_ctl                     <= RST_CLK_CTL & CLK_CTL_WMASK;
            c_reg.pwr_port                    <= RST_PWR_PORT;
            c_reg.fmt_ctl                     <= RST_FMT_CTL;
            c_reg.pwr.regulator_enable        <= RST_PWR_PORT[BIT_REG_EN];
            c_reg.pwr.vref_enable             <= RST_PWR_PORT[BIT_VREF_EN];
            c_reg.pwr.channel_enable          <= RST_PWR_PORT[CHAN_LSB +: 4];
            c_reg.clk.clock_multiplier_select <= RST_CLK_CTL[MCS_LSB +: 3];
            c_reg.clk.ratio                   <= RATIO_256;
            c_reg.clk.mute                    <= RST_CLK_CTL[BIT_AUTOMUTE];
            c_reg.rate                        <= RST_FMT_CTL[RATE_LSB +: 3];
        end else begin
            c_reg <= c_next;
        end
    end

    assign reg_rdata         = c_reg.rdata;
    assign pwr_out           = c_reg.pwr;
    assign clk_out           = c_reg.clk;
    assign sample_rate_range = c_reg.rate;
    assign src_rate_bad      = c_reg.rate_bad;

    // ------------------------------------------------------------------------
    // link side, clocked by the bit clock
    // ------------------------------------------------------------------------
    always_comb begin
        logic [9:0] fbits;
        logic [8:0] pos_n;
        logic [4:0] dly;
        logic [4:0] wid;
        logic [4:0] b;
        logic [4:0] k;
        logic [3:0] slot;
        logic [23:0] smp;
        cps_frame_t cur;
        fbits = FRAME_BITS_2;
        pos_n = '0;
        dly = DLY_LJ;
        wid = WID_24;
        b = '0;
        k = '0;
        slot = '0;
        smp = '0;
        cur = '0;
        l_next          = l_reg;
        l_next.cfg_s0   = link_cfg;
        l_next.cfg_s1   = l_reg.cfg_s0;
        l_next.req_sync = {l_reg.req_sync[0], c_reg.req};
        l_next.lr_sync  = {l_reg.lr_sync[0], lrclk_in};
        l_next.lr_prev  = l_reg.lr_sync[1];
        case (l_reg.cfg_s1.port_mode_select) // R11
            MODE_TDM4:  fbits = FRAME_BITS_4;
            MODE_TDM8:  fbits = FRAME_BITS_8;
            MODE_TDM16: fbits = FRAME_BITS_16;
            default:    fbits = FRAME_BITS_2;
        endcase
        // frame opens when the frame clock enters its first-half level
        if (l_reg.lr_sync[1] == l_reg.cfg_s1.frame_clock_polarity &&
            l_reg.lr_prev != l_reg.cfg_s1.frame_clock_polarity) begin // R06
            pos_n = LINK_LAT;
        // a position left past the end by a mode change wraps at once
        end else if ({1'b0, l_reg.pos} >= fbits - 10'h001) begin // R11
            pos_n = '0;
        end else begin
            pos_n = l_reg.pos + 9'h001;
        end
        cur = l_reg.word;
        if (pos_n == '0) begin
            // no fresh word at frame start sends silence instead of a stale one
            cur = '0;
            if (l_reg.req_sync[1] != l_reg.ack && !l_reg.cfg_s1.soft_reset) begin
                cur        = c_reg.hold;
                l_next.ack = ~l_reg.ack;
            end
        end
        case (l_reg.cfg_s1.serial_format_select) // R10
            CPS_FMT_DELAY1: dly = DLY_DELAY1;
            CPS_FMT_LJ:     dly = DLY_LJ;
            CPS_FMT_RJ24:   dly = DLY_RJ24;
            CPS_FMT_RJ16:   dly = DLY_RJ16;
        endcase
        wid  = (l_reg.cfg_s1.serial_format_select == CPS_FMT_RJ16) ? WID_16 : WID_24;
        slot = pos_n[8:5];
        b    = pos_n[4:0];
        k    = b - dly;
        smp  = (slot < 4'h4) ? cur.ch[slot[1:0]] : 24'h000000;
        l_next.sout = (b >= dly && k < wid) ? smp[MSB_IDX - k] : 1'b0; // R10
        l_next.pos  = pos_n;
        l_next.word = cur;
        if (l_reg.cfg_s1.soft_reset) begin // R13
            l_next.pos  = '0;
            l_next.word = '0;
            l_next.sout = 1'b0;
        end
    end

    always_ff @(posedge bclk or negedge arst_n) begin
        if (!arst_n) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // falling-edge copy so data can change on either bit clock edge
    always_ff @(negedge bclk or negedge arst_n) begin
        if (!arst_n) begin
            sout_neg_reg <= 1'b0;
        end else begin
            sout_neg_reg <= l_reg.sout;
        end
    end

    assign sdata_out = l_reg.cfg_s1.bit_edge_select ? l_reg.sout : sout_neg_reg; // R07

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_lock_flag_read: assert property (@(posedge mclk) disable iff (!arst_n) // R01
        (reg_addr == OFF_CLK_CTL && $past(loop_locked) == loop_locked && $past(loop_locked, 2) == loop_locked)
        |=> reg_rdata[BIT_LOCK] == $past(loop_locked))
        else $error("lock flag does not follow the loop");
    a_automute_on: assert property (@(posedge mclk) disable iff (!arst_n) // R02
        (c_reg.clk_ctl[BIT_AUTOMUTE] && !c_reg.lock_sync[1] && !soft_rst) |=> clk_out.mute)
        else $error("no mute on loop unlock");
    a_automute_off: assert property (@(posedge mclk) disable iff (!arst_n) // R02
        (reg_wr && reg_addr == OFF_CLK_CTL && !reg_wdata[BIT_AUTOMUTE] && !soft_rst) |=> !clk_out.mute)
        else $error("mute with automute disabled");
    a_ratio_code: assert property (@(posedge mclk) disable iff (!arst_n) // R04
        (clk_out.clock_multiplier_select == MCS_768) |-> (clk_out.ratio == RATIO_768))
        else $error("multiplier ratio wrong");
    a_soft_reset_pwr: assert property (@(posedge mclk) disable iff (!arst_n) // R13
        soft_rst |=> (pwr_out == RST_PWR_PORT[5:0] && sample_rate_range == RATE_32K))
        else $error("soft reset left state");
    a_power_write: assert property (@(posedge mclk) disable iff (!arst_n) // R08
        (reg_wr && reg_addr == OFF_PWR_PORT && !soft_rst)
        |=> (pwr_out.regulator_enable == $past(reg_wdata[BIT_REG_EN]) &&
             pwr_out.channel_enable == $past(reg_wdata[3:0])))
        else $error("power enables not written");
    a_delay_first_bit: assert property (@(posedge bclk) disable iff (!arst_n) // R10
        (l_reg.cfg_s1.serial_format_select == CPS_FMT_DELAY1 && l_reg.pos[4:0] == 5'h00) |-> !l_reg.sout)
        else $error("first slot bit not delayed");
    a_frame_wrap: assert property (@(posedge bclk) disable iff (!arst_n) // R11
        (l_reg.cfg_s1.port_mode_select == MODE_STEREO && $past(l_reg.cfg_s1.port_mode_select) == MODE_STEREO)
        |-> (l_reg.pos < 9'h040))
        else $error("stereo frame too long");
    c_word_sent: cover property (@(posedge bclk) disable iff (!arst_n) l_reg.ack != $past(l_reg.ack));
    c_muted_take: cover property (@(posedge mclk) disable iff (!arst_n) take && muted);
    c_tdm16: cover property (@(posedge bclk) disable iff (!arst_n) l_reg.pos == 9'h1ff);
endmodule
`default_nettype wire

// ---- sim/cps_host_model.sv ----
// host receiver model: makes bit and frame clocks, keeps the last non-silent slot-0 word
`timescale 1ns/10ps
`default_nettype none
module cps_host_model (
    output logic        bclk,
    output logic        lrclk,
    input  wire logic   sdata,
    output logic [23:0] got
);
    logic [5:0]  pos = 6'h3f;
    logic [23:0] sh = 24'h0;
    initial bclk = 1'b0;
    initial lrclk = 1'b1;
    initial got = 24'h0;
    // free running: the transmitter needs a continuous bit clock
    always #62.5 bclk = ~bclk;
    always @(negedge bclk) begin
        pos <= pos + 6'h01;
        lrclk <= (pos + 6'h01) >= 6'h20;
    end
    always @(posedge bclk) begin
        if (pos >= 6'h01 && pos <= 6'h18) sh <= {sh[22:0], sdata};
        if (pos == 6'h19 && sh != 24'h0) got <= sh;
    end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the clock, power and serial port control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cps_pkg::*;
();
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        soft_rst = 1'b0;
    logic        loop_locked = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        samp_valid = 1'b0;
    cps_frame_t  samp_data = '0;
    logic [7:0]  reg_rdata;
    logic        samp_ready;
    cps_power_t  pwr_out;
    cps_clock_t  clk_out;
    logic [2:0]  rate;
    logic        src_bad;
    logic        bclk;
    logic        lrclk;
    logic        sdata;
    logic [23:0] got;
    int          mismatches = 0;
    int          n_tests = 0;
    int          takes;
    always #5 mclk = ~mclk;
    cps_config_top DUT (.mclk(mclk), .arst_n(arst_n), .soft_rst(soft_rst), .loop_locked(loop_locked),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .samp_valid(samp_valid), .samp_ready(samp_ready), .samp_data(samp_data), .pwr_out(pwr_out),
        .clk_out(clk_out), .sample_rate_range(rate), .src_rate_bad(src_bad), .bclk(bclk),
        .lrclk_in(lrclk), .sdata_out(sdata));
    cps_host_model host (.bclk(bclk), .lrclk(lrclk), .sdata(sdata), .got(got));
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one extra cycle so registered outputs have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        chk({16'h0, reg_rdata}, {16'h0, e});
    endtask
    task automatic tally_and_finish;
        $display("counts tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_reset;
        rdchk(8'h01, 8'h41);
        rdchk(8'h04, 8'h3f);
        rdchk(8'h05, 8'h02);
        rdchk(8'h02, 8'h00);
        chk({14'h0, clk_out.ratio}, 24'h000100);
        chk({23'h0, clk_out.mute}, 24'h1);
        $display("reset values done");
    endtask
    task automatic t_lock;
        loop_locked = 1'b1;
        repeat (6) @(negedge mclk);
        rdchk(8'h01, 8'hc1);
        chk({23'h0, clk_out.mute}, 24'h0);
        wr(8'h01, 8'hb1);
        loop_locked = 1'b0;
        wr(8'h05, 8'h00);
        repeat (6) @(negedge mclk);
        rdchk(8'h01, 8'h31);
        chk({21'h0, clk_out.frame_source, clk_out.mute, src_bad}, 24'h5);
        $display("lock and automute done");
    endtask
    task automatic t_codes;
        logic [9:0] tab [8] = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h300, 10'h0, 10'h0, 10'h0};
        for (int k = 0; k < 8; k++) begin
            wr(8'h01, {5'h00, k[2:0]});
            chk({11'h0, clk_out.clock_multiplier_select, clk_out.ratio}, {11'h0, k[2:0], tab[k]});
        end
        for (int m = 0; m < 5; m++) begin
            wr(8'h05, {m[1:0], m[2:0], 3'h4});
            rdchk(8'h05, {m[1:0], m[2:0], 3'h4});
        end
        chk({21'h0, rate}, 24'h000004);
        wr(8'h04, 8'h2a);
        chk({18'h0, pwr_out}, 24'h00002a);
        $display("codes and power done");
    endtask
    task automatic t_soft;
        loop_locked = 1'b1;
        soft_rst = 1'b1;
        @(negedge mclk);
        soft_rst = 1'b0;
        rdchk(8'h01, 8'hc1);
        rdchk(8'h04, 8'h3f);
        rdchk(8'h05, 8'h02);
        chk({18'h0, pwr_out}, 24'h00003f);
        chk({21'h0, rate}, 24'h000002);
        $display("soft reset done");
    endtask
    task automatic t_stream;
        samp_data.ch[0] = 24'hc35a17;
        samp_data.ch[1] = 24'h5a5a5a;
        samp_valid = 1'b1;
        takes = 0;
        repeat (20) begin
            if (samp_ready === 1'b1) takes++;
            @(negedge mclk);
        end
        samp_valid = 1'b0;
        chk({23'h0, samp_ready}, 24'h0);
        chk({23'h0, takes >= 2}, 24'h1);
        for (int i = 0; i < 5000 && got === 24'h0; i++) @(negedge mclk);
        chk(got, 24'hc35a17);
        $display("stream done");
    endtask
    initial begin
        repeat (30) @(negedge mclk);
        arst_n = 1'b1;
        t_reset();
        t_lock();
        t_codes();
        t_soft();
        t_stream();
        tally_and_finish();
    end
    initial begin
        #300000;
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
